// ---- hw/sfp_pkg.sv ----
/*
 * Shared constants for the sector protection block of a serial flash:
 * opcodes, status byte layout, global protect patterns and reset values.
 * Assumes an SPI mode 0/3 host framing every command with chip select.
 */
package sfp_pkg;

	// command opcodes
	localparam logic [7:0] OP_NONE   = 8'h00;
	localparam logic [7:0] OP_WREN   = 8'h06;
	localparam logic [7:0] OP_WRDI   = 8'h04;
	localparam logic [7:0] OP_WRSR1  = 8'h01;
	localparam logic [7:0] OP_RDSR   = 8'h05;
	localparam logic [7:0] OP_RDPROT = 8'h3C;

	// status byte layout
	localparam int SR_LOCK   = 7;
	localparam int SR_FLD_HI = 5;
	localparam int SR_FLD_LO = 2;
	localparam int SR_WP     = 4;
	localparam int SR_SUM_HI = 3;
	localparam int SR_SUM_LO = 2;
	localparam int SR_WEN    = 1;

	// global protect field patterns
	localparam logic [3:0] GP_ALL_ONE  = 4'hF;
	localparam logic [3:0] GP_ALL_ZERO = 4'h0;

	// protection summary codes
	localparam logic [1:0] SUM_NONE = 2'h0;
	localparam logic [1:0] SUM_SOME = 2'h1;
	localparam logic [1:0] SUM_ALL  = 2'h3;

	// byte positions inside a frame
	localparam logic [2:0] IDX_ADDR_HI   = 3'h1;
	localparam logic [2:0] IDX_ADDR_LAST = 3'h3;
	localparam logic [2:0] IDX_LAST      = 3'h7;

	// sizes and reset values
	localparam int   DEF_SECTORS = 128;
	localparam logic PROT_RESET  = 1'b1;
	localparam logic LOCK_RESET  = 1'b0;

	// command phase, one-hot
	typedef enum logic [3:0] {
		PH_OPC  = 4'b0001,
		PH_ARG  = 4'b0010,
		PH_OUT  = 4'b0100,
		PH_SKIP = 4'b1000
	} sfp_phase_t;

endpackage

// ---- hw/sfp_link_if.sv ----
/*
 * Carrier between the serial front end and the protection core.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ps
interface sfp_link_if;
	logic       byte_vld;    // one-cycle pulse, byte complete
	logic [7:0] byte_data;
	logic [2:0] byte_idx;    // position of that byte in the frame
	logic       sck_fall;    // one-cycle pulse, falling serial clock
	logic       frame_end;   // one-cycle pulse, chip select released
	logic       end_aligned; // release fell on a byte boundary
	logic       cs_active;

	modport front (output byte_vld, byte_data, byte_idx, sck_fall,
		frame_end, end_aligned, cs_active);
	modport core (input byte_vld, byte_data, byte_idx, sck_fall,
		frame_end, end_aligned, cs_active);
endinterface

// ---- hw/sfp_spi_front.sv ----
/*
 * Serial front end: synchronises chip select, serial clock and serial in
 * into the system clock, finds clock edges and assembles bytes.
 * Assumes the serial clock is well below a quarter of the system clock.
 */
`timescale 1ns/1ps
module sfp_spi_front
	import sfp_pkg::*;
(
	// clock and reset
	input  wire logic   sys_clk_i,
	input  wire logic   rst_i,
	// serial pins
	input  wire logic   cs_n_i,
	input  wire logic   sck_i,
	input  wire logic   si_i,
	// toward the core
	sfp_link_if.front   lnk
);

	typedef struct packed {
		logic       cs_m;
		logic       cs_s;
		logic       cs_p;
		logic       sck_m;
		logic       sck_s;
		logic       sck_p;
		logic       si_m;
		logic       si_s;
		logic [2:0] bit_cnt;
		logic [2:0] byte_cnt;
		logic [7:0] shift;
		logic       byte_vld;
		logic [7:0] byte_data;
		logic [2:0] byte_idx;
		logic       sck_fall;
		logic       frame_end;
		logic       end_aligned;
	} sfp_front_t;

	sfp_front_t st_q;
	sfp_front_t st_d;

	// synchronise pins, detect edges, shift bytes
	always_comb begin
		st_d           = st_q;
		st_d.cs_m      = cs_n_i;
		st_d.cs_s      = st_q.cs_m;
		st_d.cs_p      = st_q.cs_s;
		st_d.sck_m     = sck_i;
		st_d.sck_s     = st_q.sck_m;
		st_d.sck_p     = st_q.sck_s;
		st_d.si_m      = si_i;
		st_d.si_s      = st_q.si_m;
		st_d.byte_vld  = 1'b0;
		st_d.sck_fall  = 1'b0;
		st_d.frame_end = 1'b0;
		if (st_q.cs_s) begin
			st_d.bit_cnt  = 3'h0;
			st_d.byte_cnt = 3'h0;
			if (!st_q.cs_p) begin
				st_d.frame_end   = 1'b1;
				st_d.end_aligned = (st_q.bit_cnt == 3'h0);
			end
		end else begin
			if (st_q.sck_s && !st_q.sck_p) begin
				st_d.shift   = {st_q.shift[6:0], st_q.si_s};
				st_d.bit_cnt = st_q.bit_cnt + 3'h1;
				if (st_q.bit_cnt == IDX_LAST) begin
					st_d.byte_vld  = 1'b1;
					st_d.byte_data = {st_q.shift[6:0], st_q.si_s};
					st_d.byte_idx  = st_q.byte_cnt;
					if (st_q.byte_cnt != IDX_LAST) begin
						st_d.byte_cnt = st_q.byte_cnt + 3'h1; // saturates
					end
				end
			end
			if (!st_q.sck_s && st_q.sck_p) begin
				st_d.sck_fall = 1'b1;
			end
		end
	end

	// state register, chip select idles released
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q      <= '0;
			st_q.cs_m <= 1'b1;
			st_q.cs_s <= 1'b1;
			st_q.cs_p <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// link outputs
	assign lnk.byte_vld    = st_q.byte_vld;
	assign lnk.byte_data   = st_q.byte_data;
	assign lnk.byte_idx    = st_q.byte_idx;
	assign lnk.sck_fall    = st_q.sck_fall;
	assign lnk.frame_end   = st_q.frame_end;
	assign lnk.end_aligned = st_q.end_aligned;
	assign lnk.cs_active   = !st_q.cs_s;

endmodule

// ---- hw/sfp_protect.sv ----
/*
 * Sector software protection of a serial flash: write enable latch,
 * protection lock bit, global protect/unprotect from the first status
 * byte write, status read and the read-sector-protection command.
 * Assumes a host driving chip select, serial clock and serial in in
 * SPI mode 0 or 3, and a write-protect pin that is low when asserted.
 */
`timescale 1ns/1ps
module sfp_protect
	import sfp_pkg::*;
#(
	parameter int SECTORS = DEF_SECTORS
) (
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	// serial pins
	input  wire logic       cs_n_i,
	input  wire logic       sck_i,
	input  wire logic       si_i,
	input  wire logic       wp_n_i,
	output logic            so_o,
	output logic            so_oe_o,
	// array status
	input  wire logic       suspended_i,
	// protection status
	output logic            protect_regs_locked_o,
	output logic            write_enable_latch_o,
	output logic [1:0]      software_protect_summary_o
);

	localparam int SECT_W = $clog2(SECTORS);

	// sector count must be a power of two that one address byte covers
	if (SECTORS < 2 || SECTORS > 256 || (SECTORS & (SECTORS - 1)) != 0) begin : g_chk
		$error("SECTORS must be a power of two from 2 to 256");
	end

	typedef struct packed {
		logic               wen;
		logic               lock;
		logic [SECTORS-1:0] prot;
		logic [1:0]         psum;
		logic [7:0]         opcode;
		logic [7:0]         sect;
		logic [7:0]         wdata;
		logic               wgot;
		sfp_phase_t         phase;
		logic [7:0]         out_sh;
		logic               so;
		logic               wp_m;
		logic               wp_s;
	} sfp_core_t;

	sfp_core_t   st_q;
	sfp_core_t   st_d;
	logic        wrsr_go;
	logic [3:0]  fld;
	logic [7:0]  sr;

	sfp_link_if  lnk ();

	// serial front end
	sfp_spi_front u_front (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.cs_n_i    (cs_n_i),
		.sck_i     (sck_i),
		.si_i      (si_i),
		.lnk       (lnk)
	);

	// all, some or none of the sectors protected
	function automatic logic [1:0] sum_of(input logic [SECTORS-1:0] p);
		if (&p) begin
			return SUM_ALL;
		end else if (|p) begin
			return SUM_SOME;
		end
		return SUM_NONE;
	endfunction

	// repeating read byte for the addressed sector
	function automatic logic [7:0] prot_byte(input logic [SECTORS-1:0] p,
		input logic [7:0] s);
		return {8{p[s[SECT_W-1:0]]}};
	endfunction

	// command decode, status write and serial output
	always_comb begin
		st_d      = st_q;
		st_d.wp_m = wp_n_i;
		st_d.wp_s = st_q.wp_m;
		wrsr_go   = 1'b0;
		fld       = st_q.wdata[SR_FLD_HI:SR_FLD_LO];
		sr                        = 8'h00;
		sr[SR_LOCK]               = st_q.lock;
		sr[SR_WP]                 = st_q.wp_s;
		sr[SR_SUM_HI:SR_SUM_LO]   = st_q.psum;
		sr[SR_WEN]                = st_q.wen;

		if (lnk.byte_vld) begin
			unique case (st_q.phase)
				PH_OPC: begin
					st_d.opcode = lnk.byte_data;
					if (lnk.byte_data == OP_RDSR) begin
						st_d.phase  = PH_OUT;
						st_d.out_sh = sr;
					end else if (lnk.byte_data == OP_RDPROT ||
						lnk.byte_data == OP_WRSR1) begin
						st_d.phase = PH_ARG;
					end else begin
						st_d.phase = PH_SKIP;
					end
				end
				PH_ARG: begin
					if (st_q.opcode == OP_RDPROT) begin
						if (lnk.byte_idx == IDX_ADDR_HI) begin
							st_d.sect = lnk.byte_data;
						end
						if (lnk.byte_idx == IDX_ADDR_LAST) begin
							st_d.phase  = PH_OUT;
							st_d.out_sh = prot_byte(st_q.prot, st_q.sect);
						end
					end else begin
						st_d.wdata = lnk.byte_data; // later bytes ignored
						st_d.wgot  = 1'b1;
						st_d.phase = PH_SKIP;
					end
				end
				PH_OUT: begin
					if (st_q.opcode == OP_RDPROT) begin
						st_d.out_sh = prot_byte(st_q.prot, st_q.sect);
					end else begin
						st_d.out_sh = sr;
					end
				end
				PH_SKIP: begin
				end
				default: st_d.phase = PH_SKIP;
			endcase
		end

		// shift out on the falling serial clock, msb first
		if (lnk.sck_fall && st_q.phase == PH_OUT) begin
			st_d.so     = st_q.out_sh[7];
			st_d.out_sh = {st_q.out_sh[6:0], st_q.out_sh[7]};
		end

		// commands take effect when chip select is released
		if (lnk.frame_end) begin
			st_d.phase  = PH_OPC;
			st_d.opcode = OP_NONE;
			st_d.wgot   = 1'b0;
			st_d.so     = 1'b0;
			if (lnk.end_aligned) begin
				if (st_q.opcode == OP_WREN) begin
					st_d.wen = 1'b1;
				end else if (st_q.opcode == OP_WRDI) begin
					st_d.wen = 1'b0;
				end else if (st_q.opcode == OP_WRSR1 && st_q.wgot && st_q.wen) begin
					wrsr_go  = 1'b1;
					st_d.wen = 1'b0;
				end
			end
		end

		if (wrsr_go) begin
			if (st_q.lock && !st_q.wp_s) begin
				st_d.lock = st_q.lock;
			end else if (st_q.lock) begin
				if (!st_q.wdata[SR_LOCK]) begin
					st_d.lock = 1'b0;
				end
			end else if (fld == GP_ALL_ONE && suspended_i) begin
				st_d.lock = st_q.lock;
			end else begin
				st_d.lock = st_q.wdata[SR_LOCK];
				if (fld == GP_ALL_ONE) begin
					st_d.prot = {SECTORS{1'b1}};
				end else if (fld == GP_ALL_ZERO) begin
					st_d.prot = {SECTORS{1'b0}};
				end
			end
		end

		st_d.psum = sum_of(st_d.prot);
	end

	// state register
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q       <= '0;
			st_q.prot  <= {SECTORS{PROT_RESET}};
			st_q.psum  <= SUM_ALL;
			st_q.lock  <= LOCK_RESET;
			st_q.phase <= PH_OPC;
			st_q.wp_m  <= 1'b1;
			st_q.wp_s  <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs
	assign so_o                       = st_q.so;
	// output floats once chip select is released
	assign so_oe_o                    = (st_q.phase == PH_OUT) && lnk.cs_active;
	assign protect_regs_locked_o      = st_q.lock;
	assign write_enable_latch_o       = st_q.wen;
	assign software_protect_summary_o = st_q.psum;

	// global protect sets every sector
	a_global_protect_all: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wrsr_go && !st_q.lock && fld == GP_ALL_ONE && !suspended_i
		|=> st_q.prot == {SECTORS{1'b1}} && st_q.psum == SUM_ALL)
		else $error("global protect did not set all sectors");

	// global unprotect clears every sector
	a_global_unprot_all: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wrsr_go && !st_q.lock && fld == GP_ALL_ZERO
		|=> st_q.prot == {SECTORS{1'b0}} ##1 st_q.prot == {SECTORS{1'b0}})
		else $error("global unprotect did not clear all sectors");

	// mixed patterns keep protection
	a_mixed_pattern_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wrsr_go && fld != GP_ALL_ONE && fld != GP_ALL_ZERO |=> $stable(st_q.prot))
		else $error("mixed pattern changed protection");

	// suspend aborts global protect
	a_suspend_abort: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wrsr_go && fld == GP_ALL_ONE && suspended_i |=> $stable(st_q.prot) && !st_q.wen)
		else $error("global protect during suspend not aborted");

	// hardware lock freezes lock bit and sectors
	a_hw_lock_freeze: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wrsr_go && st_q.lock && !st_q.wp_s |=> st_q.lock && $stable(st_q.prot))
		else $error("hardware lock did not hold");

	// soft lock only follows written bit 7
	a_soft_lock_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wrsr_go && st_q.lock && st_q.wp_s
		|=> $stable(st_q.prot) && st_q.lock == $past(st_q.wdata[SR_LOCK]))
		else $error("soft lock write misbehaved");

	// no write enable, no status write
	a_wen_gate_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		lnk.frame_end && !st_q.wen |=> $stable(st_q.prot) && $stable(st_q.lock))
		else $error("status write ran without write enable");

	// protection read drives the sector bit
	a_read_sector_bit: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		st_q.phase == PH_OUT && st_q.opcode == OP_RDPROT && lnk.sck_fall
		|=> st_q.so == st_q.prot[st_q.sect[SECT_W-1:0]])
		else $error("protection read bit wrong");

	// chip select release floats output
	a_cs_release_float: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		lnk.frame_end |-> !so_oe_o ##1 (!so_oe_o && st_q.phase == PH_OPC))
		else $error("output still driven after release");

endmodule

// ---- dv/sfp_host_model.sv ----
/*
 * Serial host model for the sector protection block: frames commands with
 * chip select, makes the serial clock and shifts serial in, msb first.
 * Assumes the system clock paces every serial edge, 8 clocks per period.
 */
`timescale 1ns/1ps
module sfp_host_model (
	// system clock
	input  wire logic   sys_clk_i,
	// serial pins
	output logic        cs_n_o,
	output logic        sck_o,
	output logic        si_o,
	input  wire logic   so_i,
	input  wire logic   so_oe_i,
	// last sixteen bits sampled on serial out
	output logic [15:0] rx_o
);
	// idle levels, clock parked low
	initial begin
		cs_n_o = 1'b1;
		sck_o  = 1'b0;
		si_o   = 1'b0;
		rx_o   = 16'h0000;
	end

	// data line toggles outside frames so no stale value lingers
	always @(posedge sys_clk_i) begin
		if (cs_n_o) si_o <= ~si_o;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask

	// sends nb bits taken from the top of tx, mode 0 timing
	task automatic frame(input int nb, input logic [47:0] tx);
		@(posedge sys_clk_i) cs_n_o <= 1'b0;
		wait_clk(3);
		for (int i = 0; i < nb; i++) begin
			@(posedge sys_clk_i);
			sck_o <= 1'b0;
			si_o  <= tx[47 - i];
			rx_o  <= {rx_o[14:0], so_oe_i ? so_i : 1'bx};
			wait_clk(3);
			@(posedge sys_clk_i) sck_o <= 1'b1;
			wait_clk(3);
		end
		@(posedge sys_clk_i);
		sck_o <= 1'b0;
		rx_o  <= {rx_o[14:0], so_oe_i ? so_i : 1'bx};
		wait_clk(3);
		@(posedge sys_clk_i) cs_n_o <= 1'b1;
		wait_clk(10);
	endtask
endmodule

// ---- dv/tb_top.sv ----
/*
 * Bench for the sector protection block: directed status writes and
 * protection reads through the host model, checked on the status ports and on serial out.
 * Assumes the design updates status within 10 clocks of chip select release.
 */
`timescale 1ns/1ps
module tb_top;
	import sfp_pkg::*;

	typedef struct packed {
		logic       wp;
		logic       sp;
		logic [7:0] d;
		logic [1:0] s;
		logic       l;
	} sfp_step_t;

	logic        sys_clk;
	logic        rst;
	logic        wp_n;
	logic        susp;
	logic        cs_n;
	logic        sck;
	logic        si;
	logic        so;
	logic        so_oe;
	logic        lock;
	logic        wen;
	logic [1:0]  sum;
	logic [15:0] rx;
	int          n_mismatch;
	int          compares;
	int          cycles;
	sfp_step_t   st;

	// pin, suspend, data, expected summary and lock after the write
	sfp_step_t steps [15] = '{
		'{1'b1, 1'b0, 8'h00, SUM_NONE, 1'b0},
		'{1'b1, 1'b0, 8'h1C, SUM_NONE, 1'b0},
		'{1'b1, 1'b0, 8'h7F, SUM_ALL,  1'b0},
		'{1'b1, 1'b0, 8'h38, SUM_ALL,  1'b0},
		'{1'b1, 1'b0, 8'hF0, SUM_ALL,  1'b1},
		'{1'b1, 1'b0, 8'h00, SUM_ALL,  1'b0},
		'{1'b1, 1'b0, 8'h00, SUM_NONE, 1'b0},
		'{1'b1, 1'b0, 8'hFF, SUM_ALL,  1'b1},
		'{1'b1, 1'b0, 8'h0F, SUM_ALL,  1'b0},
		'{1'b1, 1'b0, 8'h80, SUM_NONE, 1'b1},
		'{1'b0, 1'b0, 8'h7F, SUM_NONE, 1'b1},
		'{1'b0, 1'b0, 8'h0F, SUM_NONE, 1'b1},
		'{1'b1, 1'b0, 8'h7F, SUM_NONE, 1'b0},
		'{1'b1, 1'b1, 8'h3C, SUM_NONE, 1'b0},
		'{1'b0, 1'b0, 8'hFF, SUM_ALL,  1'b1}
	};

	sfp_protect i_sfp_protect (
		.sys_clk_i                  (sys_clk),
		.rst_i                      (rst),
		.cs_n_i                     (cs_n),
		.sck_i                      (sck),
		.si_i                       (si),
		.wp_n_i                     (wp_n),
		.so_o                       (so),
		.so_oe_o                    (so_oe),
		.suspended_i                (susp),
		.protect_regs_locked_o      (lock),
		.write_enable_latch_o       (wen),
		.software_protect_summary_o (sum)
	);

	sfp_host_model host (
		.sys_clk_i (sys_clk),
		.cs_n_o    (cs_n),
		.sck_o     (sck),
		.si_o      (si),
		.so_i      (so),
		.so_oe_i   (so_oe),
		.rx_o      (rx)
	);

	// clock, 40 ns period
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// hang guard, ceiling well above the planned run
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic status(input logic [1:0] s, input logic l, input logic w);
		chk("status", {12'h000, s, l, w}, {12'h000, sum, lock, wen});
	endtask

	task automatic rdprot(input logic [23:0] a, input logic [15:0] e);
		host.frame(48, {OP_RDPROT, a, 16'h0000});
		chk("prot_read", e, rx);
	endtask

	task automatic end_of_test();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// main sequence
	initial begin
		rst        = 1'b1;
		wp_n       = 1'b1;
		susp       = 1'b0;
		n_mismatch = 0;
		compares   = 0;
		cycles     = 0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (3) @(posedge sys_clk);
		status(SUM_ALL, 1'b0, 1'b0);
		rdprot(24'h7F0000, 16'hFFFF);
		host.frame(16, {OP_WRSR1, 8'h00, 32'h0});
		status(SUM_ALL, 1'b0, 1'b0);
		// enable released off a byte boundary is dropped
		host.frame(12, {OP_WREN, 40'h0});
		chk("write_enable", 16'h0000, {15'h0000, wen});
		// write disable undoes the enable, so the write is refused
		host.frame(8, {OP_WREN, 40'h0});
		host.frame(8, {OP_WRDI, 40'h0});
		host.frame(16, {OP_WRSR1, 8'h00, 32'h0});
		status(SUM_ALL, 1'b0, 1'b0);
		for (int i = 0; i < 15; i++) begin
			st = steps[i];
			@(posedge sys_clk);
			wp_n <= st.wp;
			susp <= st.sp;
			host.frame(8, {OP_WREN, 40'h0});
			chk("write_enable", 16'h0001, {15'h0000, wen});
			host.frame(16, {OP_WRSR1, st.d, 32'h0});
			status(st.s, st.l, 1'b0);
			host.frame(24, {OP_RDSR, 40'h0});
			chk("status_read", {2{st.l, 2'b00, st.wp, st.s, 2'b00}}, rx);
			rdprot({8'(i * 17), 16'hFFFF}, st.s == SUM_ALL ? 16'hFFFF : 16'h0000);
		end
		// release in mid-byte of the read-out
		host.frame(37, {OP_RDPROT, 24'h050000, 16'h0000});
		chk("so_oe", 16'h0000, {15'h0000, so_oe});
		rdprot(24'h050000, 16'hFFFF);
		end_of_test();
	end
endmodule
